// File: hw/swpm_top.sv
// sleep, wake, clock request and radio power-down control
`timescale 1ns/100ps
`include "swpm_cfg.svh"

// Operation
// - separate tx, rx, pll, pa power-down outputs
// - host request puts device to sleep
// - sleep timer on slow tick or host wakes
// - periodic session events wake, then resleep
// - transports idle asleep, wake accepted anytime
// - host wake during session keeps device awake
// - wake withdrawn lets device fall asleep
// - pin mode: wake input, host wake output
// - uart mode: cts wakes, rts wakes host
// - spi idle deselect long enough enters sleep
// - spi idle sleep enable and wait settable
// - spi select assertion wakes the device
// - spi interrupt wakes host for pending data
// - asserted wake input holds device awake
// - host wake output with selectable polarity
// - clock request while awake, polarity selectable
// - regulator restore reinitialises everything
module swpm_top import swpm_pkg::*; #(
	parameter int LPO_DIV = `SWPM_LPO_DIV,
	parameter int TW = `SWPM_TIMER_W
) (
	input wire logic MCLK_IN,
	input wire logic RST_N_IN,
	input wire logic REG_EN_IN,
	input wire swpm_transport_e TRANSPORT_SEL_IN,
	input wire logic SLEEP_REQ_IN,
	input wire logic TIMER_WAKE_EN_IN,
	input wire logic [TW-1:0] SLEEP_TIME_IN,
	input wire logic SESSION_EN_IN,
	input wire logic [TW-1:0] SESSION_PERIOD_IN,
	input wire logic EVENT_DONE_IN,
	input wire logic DEVICE_WAKE_REQUEST_IN,
	input wire logic DEVICE_WAKE_POL_IN,
	input wire logic UART_CTS_N_IN,
	input wire logic UART_RTS_FLOW_N_IN,
	input wire logic SERIAL_SELECT_N_IN,
	input wire logic SPI_IDLE_SLEEP_EN_IN,
	input wire logic [TW-1:0] SPI_IDLE_TIME_IN,
	input wire logic HOST_ATTN_IN,
	input wire logic HOST_WAKE_POL_IN,
	input wire logic CLOCK_REQUEST_POLARITY_SEL_IN,
	input wire swpm_rf_pd_s RF_ON_IN,
	output swpm_rf_pd_s RF_PD_OUT,
	output logic CLK_GATE_EN_OUT,
	output logic CLK_REQ_OUT,
	output logic HOST_WAKE_OUT,
	output logic UART_RTS_N_OUT,
	output logic SPI_INT_OUT,
	output logic AWAKE_OUT,
	output logic TRANSPORT_IDLE_OUT,
	output logic EVENT_DUE_OUT,
	output logic INIT_PULSE_OUT
);

	logic [`SWPM_SYNC_N-1:0] s1;
	logic [`SWPM_SYNC_N-1:0] s2;
	logic [`SWPM_SYNC_N-1:0] s3;
	logic [`SWPM_SYNC_N-1:0] filt;
	logic [`SWPM_SYNC_N-1:0] next_filt;
	logic [`SWPM_SYNC_N-1:0] raw;
	logic reg_ok;
	logic wake_req;
	logic [15:0] lpo_cnt;
	logic [15:0] next_lpo_cnt;
	logic lpo_tick;
	logic next_lpo_tick;
	logic [TW-1:0] sleep_cnt;
	logic [TW-1:0] next_sleep_cnt;
	logic [TW-1:0] sess_cnt;
	logic [TW-1:0] next_sess_cnt;
	logic [TW-1:0] idle_cnt;
	logic [TW-1:0] next_idle_cnt;
	logic event_due;
	logic next_event_due;
	logic timer_hit;
	logic idle_done;
	logic sleep_ok;
	swpm_state_e state;
	swpm_state_e next_state;
	logic reg_prev;
	logic next_awake;
	logic attn_pin;
	swpm_rf_pd_s next_rf_pd;
	logic next_clk_req;
	logic next_host_wake;
	logic next_rts_n;
	logic next_spi_int;

	assign raw = {REG_EN_IN, SERIAL_SELECT_N_IN, UART_CTS_N_IN, DEVICE_WAKE_REQUEST_IN};

	// a bit only moves when the second and third stage agree
	// three-stage input filter
	always_comb begin
		next_filt = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & filt);
	end

	// first stage feeds only the second, to contain metastability
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			s1 <= `SWPM_SYNC_RST;
			s2 <= `SWPM_SYNC_RST;
			s3 <= `SWPM_SYNC_RST;
			filt <= `SWPM_SYNC_RST;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			filt <= next_filt;
		end
	end

	// regulator enable gates the whole block except the rts flow-control passthrough
	assign reg_ok = filt[`SWPM_SI_REG];

	// wake request taken from the selected transport
	always_comb begin
		case (TRANSPORT_SEL_IN)
			SWPM_TR_PIN: wake_req = DEVICE_WAKE_POL_IN ? filt[`SWPM_SI_WAKE] :
				!filt[`SWPM_SI_WAKE];
			SWPM_TR_UART: wake_req = !filt[`SWPM_SI_CTS];
			SWPM_TR_SPI: wake_req = !filt[`SWPM_SI_SEL];
			default: wake_req = 1'b0;
		endcase
	end

	// slow oscillator tick from a divider on the core clock
	// slow tick for sleep timers
	always_comb begin
		next_lpo_tick = 1'b0;
		next_lpo_cnt = lpo_cnt + 16'h0001;
		if (!reg_ok) begin
			next_lpo_cnt = 16'h0000;
		end else if (lpo_cnt == 16'(LPO_DIV - 1)) begin
			next_lpo_cnt = 16'h0000;
			next_lpo_tick = 1'b1;
		end
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			lpo_cnt <= 16'h0000;
			lpo_tick <= 1'b0;
		end else begin
			lpo_cnt <= next_lpo_cnt;
			lpo_tick <= next_lpo_tick;
		end
	end

	assign timer_hit = TIMER_WAKE_EN_IN && (state == SWPM_ST_SLEEP) && (sleep_cnt == '0);
	assign idle_done = (idle_cnt == SPI_IDLE_TIME_IN);

	// sleep, session and idle timers, all counted in slow ticks
	always_comb begin
		next_sleep_cnt = sleep_cnt;
		next_sess_cnt = sess_cnt;
		next_idle_cnt = idle_cnt;
		next_event_due = 1'b0;
		// reloaded whenever awake, so each sleep gets the full time
		if (state != SWPM_ST_SLEEP) begin
			next_sleep_cnt = SLEEP_TIME_IN;
		end else if (lpo_tick && sleep_cnt != '0) begin
			next_sleep_cnt = sleep_cnt - 1'b1;
		end
		if (!SESSION_EN_IN) begin
			next_sess_cnt = '0;
		end else if (lpo_tick) begin
			if (sess_cnt >= TW'(SESSION_PERIOD_IN - 1'b1)) begin
				next_sess_cnt = '0;
				next_event_due = 1'b1;
			end else begin
				next_sess_cnt = sess_cnt + 1'b1;
			end
		end
		if (TRANSPORT_SEL_IN != SWPM_TR_SPI || !filt[`SWPM_SI_SEL] ||
			state == SWPM_ST_SLEEP) begin
			next_idle_cnt = '0;
		end else if (lpo_tick && !idle_done) begin
			next_idle_cnt = idle_cnt + 1'b1;
		end
		if (!reg_ok) begin
			next_sleep_cnt = '0;
			next_sess_cnt = '0;
			next_idle_cnt = '0;
			next_event_due = 1'b0;
		end
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sleep_cnt <= '0;
			sess_cnt <= '0;
			idle_cnt <= '0;
			event_due <= 1'b0;
		end else begin
			sleep_cnt <= next_sleep_cnt;
			sess_cnt <= next_sess_cnt;
			idle_cnt <= next_idle_cnt;
			event_due <= next_event_due;
		end
	end

	// sleep criteria per transport
	always_comb begin
		if (TRANSPORT_SEL_IN == SWPM_TR_SPI) begin
			sleep_ok = SPI_IDLE_SLEEP_EN_IN && idle_done;
		end else begin
			sleep_ok = SLEEP_REQ_IN && !wake_req;
		end
	end

	// power state machine
	always_comb begin
		next_state = state;
		case (state)
			SWPM_ST_AWAKE: begin
				if (sleep_ok) begin
					next_state = SWPM_ST_SLEEP;
				end
			end
			SWPM_ST_SLEEP: begin
				if (wake_req || timer_hit) begin
					next_state = SWPM_ST_AWAKE;
				end else if (event_due) begin
					next_state = SWPM_ST_EVENT;
				end
			end
			SWPM_ST_EVENT: begin
				if (wake_req) begin
					next_state = SWPM_ST_AWAKE;
				end else if (EVENT_DONE_IN) begin
					next_state = SWPM_ST_SLEEP;
				end
			end
			default: next_state = SWPM_ST_AWAKE;
		endcase
		if (!reg_ok) begin
			next_state = SWPM_ST_AWAKE;
		end
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state <= SWPM_ST_AWAKE;
		end else begin
			state <= next_state;
		end
	end

	// output values derived from the next state so they line up with it
	always_comb begin
		next_awake = reg_ok && (next_state != SWPM_ST_SLEEP);
		next_rf_pd = ~(RF_ON_IN & {4{next_awake}});
		next_clk_req = (next_awake == CLOCK_REQUEST_POLARITY_SEL_IN);
		attn_pin = reg_ok && HOST_ATTN_IN && (TRANSPORT_SEL_IN == SWPM_TR_PIN);
		next_host_wake = (attn_pin == HOST_WAKE_POL_IN);
		// rts low rouses a sleeping host
		next_rts_n = UART_RTS_FLOW_N_IN;
		if (TRANSPORT_SEL_IN == SWPM_TR_UART && reg_ok && HOST_ATTN_IN) begin
			next_rts_n = 1'b0;
		end
		next_spi_int = reg_ok && HOST_ATTN_IN && (TRANSPORT_SEL_IN == SWPM_TR_SPI);
	end

	// every output registered; reset levels are passive for active-low host wake and active-high clock request
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			RF_PD_OUT <= `SWPM_RF_PD_ALL;
			CLK_GATE_EN_OUT <= 1'b0;
			CLK_REQ_OUT <= 1'b0;
			HOST_WAKE_OUT <= 1'b1;
			UART_RTS_N_OUT <= 1'b1;
			SPI_INT_OUT <= 1'b0;
			AWAKE_OUT <= 1'b0;
			TRANSPORT_IDLE_OUT <= 1'b1;
			EVENT_DUE_OUT <= 1'b0;
			INIT_PULSE_OUT <= 1'b0;
			reg_prev <= 1'b0;
		end else begin
			RF_PD_OUT <= next_rf_pd;
			CLK_GATE_EN_OUT <= next_awake;
			CLK_REQ_OUT <= next_clk_req;
			HOST_WAKE_OUT <= next_host_wake;
			UART_RTS_N_OUT <= next_rts_n;
			SPI_INT_OUT <= next_spi_int;
			AWAKE_OUT <= next_awake;
			TRANSPORT_IDLE_OUT <= !next_awake;
			EVENT_DUE_OUT <= next_event_due;
			INIT_PULSE_OUT <= reg_ok && !reg_prev;
			reg_prev <= reg_ok;
		end
	end

	rf_pd_sleep_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(state == SWPM_ST_SLEEP) |-> (RF_PD_OUT == `SWPM_RF_PD_ALL))
		else $error("radio path powered while asleep");

	sleep_gate_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(state == SWPM_ST_SLEEP) |-> (!CLK_GATE_EN_OUT && TRANSPORT_IDLE_OUT))
		else $error("clocks or transport running while asleep");

	timer_wake_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(timer_hit && reg_ok) |=> (state == SWPM_ST_AWAKE))
		else $error("sleep timer did not wake device");

	event_cycle_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(state == SWPM_ST_EVENT && EVENT_DONE_IN && !wake_req && reg_ok)
		|=> (state == SWPM_ST_SLEEP))
		else $error("no return to sleep after event");

	host_wake_in_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(state != SWPM_ST_AWAKE && wake_req && reg_ok) |=> (state == SWPM_ST_AWAKE))
		else $error("host wake request ignored");

	stay_awake_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(state == SWPM_ST_AWAKE && wake_req && reg_ok &&
		TRANSPORT_SEL_IN != SWPM_TR_SPI) |=> (state == SWPM_ST_AWAKE))
		else $error("slept while wake held");

	fall_asleep_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(state == SWPM_ST_AWAKE && sleep_ok && reg_ok) |=>
		(state == SWPM_ST_SLEEP && !AWAKE_OUT))
		else $error("did not fall asleep");

	spi_select_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		(state == SWPM_ST_SLEEP && TRANSPORT_SEL_IN == SWPM_TR_SPI &&
		!filt[`SWPM_SI_SEL] && reg_ok) |=> AWAKE_OUT)
		else $error("spi select did not wake device");

	clk_req_pol_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		$past(reg_ok) |-> (CLK_REQ_OUT == (AWAKE_OUT == $past(CLOCK_REQUEST_POLARITY_SEL_IN))))
		else $error("clock request level wrong");

	reinit_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
		$rose(reg_ok) |=> (INIT_PULSE_OUT && state == SWPM_ST_AWAKE) ##1 !INIT_PULSE_OUT)
		else $error("no reinitialisation on power restore");

endmodule // swpm_top

// File: hw/swpm_cfg.svh
// constants of the sleep and wake power manager
`ifndef SWPM_CFG_SVH
`define SWPM_CFG_SVH
`define SWPM_LPO_DIV 305
`define SWPM_TIMER_W 16
`define SWPM_SYNC_N 4
`define SWPM_SI_WAKE 0
`define SWPM_SI_CTS 1
`define SWPM_SI_SEL 2
`define SWPM_SI_REG 3
`define SWPM_SYNC_RST 4'h7
`define SWPM_RF_PD_ALL 4'hF
`endif

// File: hw/swpm_pkg.sv
// types of the sleep and wake power manager
package swpm_pkg;
	typedef enum logic [1:0] {SWPM_ST_AWAKE, SWPM_ST_SLEEP, SWPM_ST_EVENT} swpm_state_e;
	typedef enum logic [1:0] {SWPM_TR_PIN, SWPM_TR_UART, SWPM_TR_SPI} swpm_transport_e;
	typedef struct packed {
		logic tx;
		logic rx;
		logic pll;
		logic pa;
	} swpm_rf_pd_s;
endpackage

// File: verif/swpm_host_model.sv
// host side model: wake pins and regulator enable
`timescale 1ns/100ps
module swpm_host_model import swpm_pkg::*; (
	input wire logic want_in,
	input wire logic pol_in,
	input wire logic reg_in,
	input wire swpm_transport_e mode_in,
	output logic wake_out,
	output logic cts_n_out,
	output logic sel_n_out,
	output logic reg_en_out
);
	// wake pin, neutral outside pin mode
	assign wake_out = (mode_in == SWPM_TR_PIN) ? (want_in ~^ pol_in) : ~pol_in;
	assign cts_n_out = !(want_in && mode_in == SWPM_TR_UART);
	// select held low while host is active
	assign sel_n_out = !(want_in && mode_in == SWPM_TR_SPI);
	assign reg_en_out = reg_in;
endmodule // swpm_host_model

// File: verif/tb_swpm_top.sv
// self-checking bench of the sleep and wake power manager
`timescale 1ns/100ps
module tb_swpm_top import swpm_pkg::*;;
	logic clk, rst_n, reg_c, want, wpol, sreq, ten, sen, edone, hattn, hpol, cpol, ien, rfl;
	logic wk, cts_n, sel_n, reg_en, gate, creq, hwake, rts_n, sint, awake, idle, edue, init;
	logic [15:0] stime, sper, itime;
	swpm_transport_e mode;
	swpm_rf_pd_s rf_on, rf_pd;
	logic [2:0] mon;
	logic [7:0] vec;
	int n_fail, cmp_count, cyc;
	assign mon = {init, edue, awake};
	assign vec = {1'b0, rf_pd, gate, creq, idle};
	swpm_host_model u_swpm_host_model (.want_in(want), .pol_in(wpol), .reg_in(reg_c),
		.mode_in(mode), .wake_out(wk), .cts_n_out(cts_n), .sel_n_out(sel_n),
		.reg_en_out(reg_en));
	// short slow tick keeps the run brief
	swpm_top #(.LPO_DIV(4)) u_swpm_top (.MCLK_IN(clk), .RST_N_IN(rst_n), .REG_EN_IN(reg_en),
		.TRANSPORT_SEL_IN(mode), .SLEEP_REQ_IN(sreq), .TIMER_WAKE_EN_IN(ten),
		.SLEEP_TIME_IN(stime), .SESSION_EN_IN(sen), .SESSION_PERIOD_IN(sper),
		.EVENT_DONE_IN(edone), .DEVICE_WAKE_REQUEST_IN(wk), .DEVICE_WAKE_POL_IN(wpol),
		.UART_CTS_N_IN(cts_n), .UART_RTS_FLOW_N_IN(rfl), .SERIAL_SELECT_N_IN(sel_n),
		.SPI_IDLE_SLEEP_EN_IN(ien), .SPI_IDLE_TIME_IN(itime), .HOST_ATTN_IN(hattn),
		.HOST_WAKE_POL_IN(hpol), .CLOCK_REQUEST_POLARITY_SEL_IN(cpol), .RF_ON_IN(rf_on),
		.RF_PD_OUT(rf_pd), .CLK_GATE_EN_OUT(gate), .CLK_REQ_OUT(creq),
		.HOST_WAKE_OUT(hwake), .UART_RTS_N_OUT(rts_n), .SPI_INT_OUT(sint),
		.AWAKE_OUT(awake), .TRANSPORT_IDLE_OUT(idle), .EVENT_DUE_OUT(edue),
		.INIT_PULSE_OUT(init));
	// clock generator
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task chk(input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task cyc_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	// bounded wait on a monitored output, then compare
	task wt(input int s, input logic v, input int n);
		int i;
		for (i = 0; i < n && mon[s] !== v; i++) @(negedge clk);
		chk({7'h00, v}, {7'h00, mon[s]});
	endtask
	task results();
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// hang guard, far above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			results();
		end
	end
	// main sequence, inputs change at falling edges only
	initial begin
		rst_n = 1'b0;
		reg_c = 1'b0;
		want = 1'b0;
		wpol = 1'b0;
		sreq = 1'b0;
		ten = 1'b0;
		sen = 1'b0;
		edone = 1'b0;
		hattn = 1'b0;
		hpol = 1'b0;
		cpol = 1'b1;
		ien = 1'b0;
		stime = 16'h0003;
		sper = 16'h0003;
		itime = 16'h0003;
		rfl = 1'b1;
		mode = SWPM_TR_PIN;
		rf_on = 4'hA;
		cyc_n(16);
		chk(8'h79, vec);
		rst_n = 1'b1;
		reg_c = 1'b1;
		wt(2, 1'b1, 10);
		wt(0, 1'b1, 3);
		cyc_n(1);
		chk(8'h2E, vec);
		// wake settles first, so a dip into sleep would show
		want = 1'b1;
		cyc_n(6);
		sreq = 1'b1;
		cyc_n(20);
		chk(8'h01, {7'h00, awake});
		want = 1'b0;
		wt(0, 1'b0, 8);
		chk(8'h79, vec);
		cpol = 1'b0;
		cyc_n(2);
		chk(8'h7B, vec);
		cpol = 1'b1;
		sen = 1'b1;
		wt(1, 1'b1, 40);
		cyc_n(1);
		chk(8'h01, {7'h00, awake});
		edone = 1'b1;
		cyc_n(1);
		edone = 1'b0;
		wt(0, 1'b0, 4);
		want = 1'b1;
		wt(0, 1'b1, 8);
		wt(1, 1'b1, 40);
		edone = 1'b1;
		cyc_n(1);
		edone = 1'b0;
		cyc_n(3);
		chk(8'h01, {7'h00, awake});
		sen = 1'b0;
		want = 1'b0;
		wt(0, 1'b0, 8);
		// low level no longer wakes once polarity is high
		wpol = 1'b1;
		cyc_n(10);
		chk(8'h00, {7'h00, awake});
		want = 1'b1;
		wt(0, 1'b1, 8);
		ten = 1'b1;
		want = 1'b0;
		wpol = 1'b0;
		wt(0, 1'b0, 8);
		wt(0, 1'b1, 30);
		ten = 1'b0;
		wt(0, 1'b0, 4);
		hattn = 1'b1;
		hpol = 1'b1;
		cyc_n(2);
		chk(8'h01, {7'h00, hwake});
		hpol = 1'b0;
		cyc_n(2);
		chk(8'h00, {7'h00, hwake});
		hattn = 1'b0;
		cyc_n(2);
		chk(8'h01, {7'h00, hwake});
		mode = SWPM_TR_UART;
		hattn = 1'b1;
		cyc_n(2);
		chk(8'h00, {7'h00, rts_n});
		hattn = 1'b0;
		cyc_n(2);
		chk(8'h01, {7'h00, rts_n});
		// normal flow control still passes through
		rfl = 1'b0;
		cyc_n(2);
		chk(8'h00, {7'h00, rts_n});
		rfl = 1'b1;
		want = 1'b1;
		wt(0, 1'b1, 8);
		want = 1'b0;
		wt(0, 1'b0, 8);
		// spi idle sleep: host sleep request plays no part here
		mode = SWPM_TR_SPI;
		sreq = 1'b0;
		ien = 1'b1;
		want = 1'b1;
		wt(0, 1'b1, 8);
		cyc_n(30);
		chk(8'h01, {7'h00, awake});
		want = 1'b0;
		cyc_n(4);
		chk(8'h01, {7'h00, awake});
		wt(0, 1'b0, 30);
		hattn = 1'b1;
		cyc_n(2);
		chk(8'h01, {7'h00, sint});
		hattn = 1'b0;
		want = 1'b1;
		wt(0, 1'b1, 8);
		reg_c = 1'b0;
		wt(0, 1'b0, 8);
		chk(8'h79, vec);
		reg_c = 1'b1;
		wt(2, 1'b1, 10);
		results();
	end
endmodule // tb_swpm_top
